// file: rtl/i2cpc_params.svh
// Register offsets, field positions, mode codes and reset values of the port.
`ifndef I2CPC_PARAMS_SVH
`define I2CPC_PARAMS_SVH
`define I2CPC_OFS_CTL1   3'h0
`define I2CPC_OFS_CTL2   3'h1
`define I2CPC_OFS_BUF    3'h2
`define I2CPC_OFS_ADDR   3'h3
`define I2CPC_OFS_STAT   3'h4
`define I2CPC_B_WRITE_COLLISION     7
`define I2CPC_B_OVF      6
`define I2CPC_B_EN       5
`define I2CPC_B_CKP      4
`define I2CPC_B_GENERAL_CALL_IRQ_ENABLE     7
`define I2CPC_B_ACK_RECEIVED_STATUS  6
`define I2CPC_B_ACK_VALUE_TO_SEND    5
`define I2CPC_B_ACK_SEQUENCE_REQUEST    4
`define I2CPC_B_MASTER_RECEIVE_REQUEST     3
`define I2CPC_B_PEN      2
`define I2CPC_B_RESTART_REQUEST     1
`define I2CPC_B_SEN      0
`define I2CPC_M_SL7      4'h6
`define I2CPC_M_SL10     4'h7
`define I2CPC_M_MST      4'h8
`define I2CPC_M_MSK      4'h9
`define I2CPC_M_FWM      4'hB
`define I2CPC_M_SL7SS    4'hE
`define I2CPC_M_SL10SS   4'hF
`define I2CPC_CTL_RST    8'h00
`define I2CPC_ADDR_RST   8'h00
`define I2CPC_MSK_RST    8'hFF
`define I2CPC_GENCALL    8'h00
`define I2CPC_TENHDR     5'h1E
`define I2CPC_NO_REQ     5'h00
`define I2CPC_BIT_ACK    4'h8
`define I2CPC_BIT_END    4'h9
`define I2CPC_PH_HIGH    2'h2
`define I2CPC_PH_LAST    2'h3
`define I2CPC_STAT_PAD   4'h0
`endif

// file: rtl/i2cpc_pkg.sv
// Types shared by the port control logic.
package i2cpc_pkg;
	typedef enum logic [2:0] {
		MD_NONE, MD_SLAVE7, MD_SLAVE10, MD_SLAVE7_SS, MD_SLAVE10_SS, MD_MASTER, MD_MASK, MD_FWMASTER
	} i2cpc_mode_e;
	typedef enum logic [2:0] {
		MS_IDLE, MS_START, MS_RSTART, MS_STOP, MS_TX, MS_RX, MS_ACK
	} i2cpc_mst_e;
endpackage

// file: rtl/i2cpc_brg_if.sv
// Link between the control logic and its baud rate generator.
`timescale 1ns/1ns
interface i2cpc_brg_if;
	logic [6:0] reload;
	logic       run;
	logic       tick;
	modport gen (input reload, input run, output tick);
	modport user (output reload, output run, input tick);
endinterface

// file: rtl/i2cpc_brg.sv
// Baud rate generator giving one tick per quarter of a serial clock period.
`timescale 1ns/1ns
module i2cpc_brg (
	input  wire logic  clk_i,     // system clock
	input  wire logic  sys_rst_i, // synchronous reset
	i2cpc_brg_if.gen   brg        // reload, run and tick
);
	logic [6:0] count_r;
	logic       tick_r;

	assign brg.tick = tick_r;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			count_r <= '0;
			tick_r  <= 1'b0;
		end else if (!brg.run) begin
			count_r <= brg.reload;
			tick_r  <= 1'b0;
		end else if (count_r == '0) begin
			count_r <= brg.reload;
			tick_r  <= 1'b1;
		end else begin
			count_r <= count_r - 7'h01;
			tick_r  <= 1'b0;
		end
	end
endmodule

// file: rtl/i2cpc_top.sv
// Control registers and bus engines of a two-wire serial port.
// What this block does
// - Master buffer write while busy flags collision
// - Slave buffer write while shifting flags collision
// - Byte arriving onto full buffer flags overflow
// - Enable bit hands both pins to port
// - Slave clock release bit; zero holds clock
// - Slave modes: 7/10-bit, optional start/stop events
// - Master clock is system clock over 4(reload+1)
// - Firmware master mode keeps slave idle
// - Mask mode redirects address register accesses
// - Mask mode needs masking configuration bit
// - Other mode codes select nothing
// - Master transmit records slave acknowledge
// - Acknowledge value sent after received byte
// - Acknowledge request drives sequence, self-clears
// - Receive enable clocks in one byte
// - Stop request makes stop, self-clears
// - Restart request makes repeated start, self-clears
// - Start request makes start, self-clears
// - While active, no new requests or buffer writes
// - General call enable raises event
// - Slave stretch enable holds clock after byte
// - Lower seven address bits reload baud generator
// - Active means master mode and either transmitting or any request set
`timescale 1ns/1ns
module i2cpc_top (
	input  wire logic       clk_i,                  // system clock
	input  wire logic       sys_rst_i,              // synchronous reset
	input  wire logic [2:0] reg_addr_i,             // register index
	input  wire logic [7:0] reg_wdata_i,            // write data
	input  wire logic       reg_we_i,               // write strobe
	input  wire logic       reg_re_i,               // read strobe
	output logic      [7:0] reg_rdata_o,            // read data, cycle after strobe
	input  wire logic       mask_mode_config_bit_i, // static device configuration
	input  wire logic       serial_data_pin_i,      // data line level
	output logic            serial_data_pin_o,      // data drive value, always low
	output logic            serial_data_pin_oe_o,   // data pulled low
	input  wire logic       serial_clock_pin_i,     // clock line level
	output logic            serial_clock_pin_o,     // clock drive value, always low
	output logic            serial_clock_pin_oe_o,  // clock pulled low
	output logic            pins_to_port_o,         // pins owned by the port
	output logic            port_event_o            // one-cycle event pulse
);
	`include "i2cpc_params.svh"
	import i2cpc_pkg::*;

	function automatic i2cpc_mode_e mode_dec(input logic [3:0] m, input logic msk_ok);
		unique case (m)
			`I2CPC_M_SL7:    mode_dec = MD_SLAVE7;
			`I2CPC_M_SL10:   mode_dec = MD_SLAVE10;
			`I2CPC_M_SL7SS:  mode_dec = MD_SLAVE7_SS;
			`I2CPC_M_SL10SS: mode_dec = MD_SLAVE10_SS;
			`I2CPC_M_MST:    mode_dec = MD_MASTER;
			`I2CPC_M_FWM:    mode_dec = MD_FWMASTER;
			`I2CPC_M_MSK:    mode_dec = msk_ok ? MD_MASK : MD_NONE;
			default:         mode_dec = MD_NONE;
		endcase
	endfunction

	logic [7:0] ctl1_r, ctl2_r, buf_r, addr_r, msk_r, rdata_r, msh_r, txs_r;
	logic       bf_r, tip_r, sda_m_r, sda_s_r, scl_m_r, scl_s_r, sda_p_r, scl_p_r;
	logic       sda_oe_r, scl_oe_r, own_r, evt_r;
	logic [1:0] ph_r;
	logic [3:0] bit_r, cnt_r;
	logic [7:0] ssh_r;
	logic       sv_on_r, sv_adr_r, sv_hit_r, sv_tx_r, sv_busy_r, sv_ack_r;
	i2cpc_mst_e ms_r;
	i2cpc_mode_e md;
	logic en, mst_md, slv_md, ten, ss_ev, active, stretch_en;
	logic wr1, wr2, wrb, wra, rdb, msk_sel;
	logic m_scl_low, m_sda_low, m_end, m_smp, m_done;
	logic start_c, stop_c, rise, fall, hit_now;
	logic write_collision_set, ovf_set, ack_set, ckp_clr, rx_load, sv_load;
	logic [4:0] req_clr;

	i2cpc_brg_if brg ();
	i2cpc_brg u_brg (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.brg       (brg)
	);

	assign en         = ctl1_r[`I2CPC_B_EN];
	assign md         = mode_dec(ctl1_r[3:0], mask_mode_config_bit_i);
	assign mst_md     = en && (md == MD_MASTER || md == MD_FWMASTER);
	assign slv_md     = en && (md == MD_SLAVE7 || md == MD_SLAVE10 || md == MD_SLAVE7_SS || md == MD_SLAVE10_SS);
	assign ten        = md == MD_SLAVE10 || md == MD_SLAVE10_SS;
	assign ss_ev      = md == MD_SLAVE7_SS || md == MD_SLAVE10_SS;
	assign stretch_en = ctl2_r[`I2CPC_B_SEN];
	assign active     = mst_md && (tip_r || ctl2_r[4:0] != `I2CPC_NO_REQ);
	assign msk_sel    = md == MD_MASK;
	assign wr1        = reg_we_i && reg_addr_i == `I2CPC_OFS_CTL1;
	assign wr2        = reg_we_i && reg_addr_i == `I2CPC_OFS_CTL2;
	assign wrb        = reg_we_i && reg_addr_i == `I2CPC_OFS_BUF;
	assign wra        = reg_we_i && reg_addr_i == `I2CPC_OFS_ADDR;
	assign rdb        = reg_re_i && reg_addr_i == `I2CPC_OFS_BUF;
	assign brg.reload = addr_r[6:0];
	assign brg.run    = ms_r != MS_IDLE;
	assign m_end      = brg.tick && ph_r == `I2CPC_PH_LAST;
	assign m_smp      = brg.tick && ph_r == `I2CPC_PH_HIGH;
	assign start_c    = scl_s_r && scl_p_r && sda_p_r && !sda_s_r;
	assign stop_c     = scl_s_r && scl_p_r && !sda_p_r && sda_s_r;
	assign rise       = scl_s_r && !scl_p_r;
	assign fall       = !scl_s_r && scl_p_r;
	assign hit_now    = ssh_r == `I2CPC_GENCALL ? ctl2_r[`I2CPC_B_GENERAL_CALL_IRQ_ENABLE] :
	                    ten ? (ssh_r[7:3] == `I2CPC_TENHDR && ssh_r[2:1] == addr_r[2:1]) :
	                    ssh_r[7:1] == addr_r[7:1];
	assign sv_load    = slv_md && sv_on_r && fall && cnt_r == `I2CPC_BIT_ACK && !sv_tx_r
	                    && (sv_adr_r ? hit_now : sv_hit_r);
	assign ckp_clr    = slv_md && sv_on_r && fall && cnt_r == `I2CPC_BIT_END && sv_hit_r && stretch_en;
	assign rx_load    = ms_r == MS_RX && m_end && bit_r == 4'h7;
	assign write_collision_set   = wrb && ((active) || (slv_md && sv_tx_r && sv_busy_r));
	assign ovf_set    = (rx_load || sv_load) && (bf_r || ctl1_r[`I2CPC_B_OVF]);
	assign ack_set    = ms_r == MS_TX && m_smp && bit_r == `I2CPC_BIT_ACK;

	// Master pin drive for each engine state and quarter phase.
	always_comb begin
		m_scl_low = 1'b0;
		m_sda_low = 1'b0;
		unique case (ms_r)
			MS_IDLE: begin
				// Between conditions the lines keep their last level, so the clock stays low after a start.
				m_sda_low = sda_oe_r;
				m_scl_low = scl_oe_r;
			end
			MS_START: begin
				m_sda_low = ph_r != 2'h0;
				m_scl_low = ph_r == `I2CPC_PH_LAST;
			end
			MS_RSTART: begin
				m_sda_low = ph_r[1];
				m_scl_low = ph_r == 2'h0 || ph_r == `I2CPC_PH_LAST;
			end
			MS_STOP: begin
				m_sda_low = !ph_r[1];
				m_scl_low = ph_r == 2'h0;
			end
			MS_TX: begin
				m_sda_low = bit_r != `I2CPC_BIT_ACK && !msh_r[7];
				m_scl_low = ph_r == 2'h0 || ph_r == `I2CPC_PH_LAST;
			end
			MS_RX: begin
				m_scl_low = ph_r == 2'h0 || ph_r == `I2CPC_PH_LAST;
			end
			MS_ACK: begin
				m_sda_low = !ctl2_r[`I2CPC_B_ACK_VALUE_TO_SEND];
				m_scl_low = ph_r == 2'h0 || ph_r == `I2CPC_PH_LAST;
			end
		endcase
	end

	// Completed conditions release their request bits.
	always_comb begin
		req_clr = `I2CPC_NO_REQ;
		m_done  = 1'b0;
		if (m_end) begin
			unique case (ms_r)
				MS_START:  req_clr[`I2CPC_B_SEN] = 1'b1;
				MS_RSTART: req_clr[`I2CPC_B_RESTART_REQUEST] = 1'b1;
				MS_STOP:   req_clr[`I2CPC_B_PEN] = 1'b1;
				MS_ACK:    req_clr[`I2CPC_B_ACK_SEQUENCE_REQUEST] = 1'b1;
				MS_RX:     req_clr[`I2CPC_B_MASTER_RECEIVE_REQUEST] = bit_r == 4'h7;
				default:   req_clr = `I2CPC_NO_REQ;
			endcase
			m_done = ms_r != MS_IDLE && (ms_r != MS_RX || bit_r == 4'h7)
			         && (ms_r != MS_TX || bit_r == `I2CPC_BIT_ACK);
		end
	end

	// Two-flop synchronisers and edge history of the bus lines.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			{sda_m_r, sda_s_r, sda_p_r} <= 3'h7;
			{scl_m_r, scl_s_r, scl_p_r} <= 3'h7;
		end else begin
			{sda_m_r, sda_s_r, sda_p_r} <= {serial_data_pin_i, sda_m_r, sda_s_r};
			{scl_m_r, scl_s_r, scl_p_r} <= {serial_clock_pin_i, scl_m_r, scl_s_r};
		end
	end

	// Control register one; hardware sets win over software clears.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctl1_r <= `I2CPC_CTL_RST;
		end else begin
			ctl1_r[`I2CPC_B_WRITE_COLLISION] <= (wr1 ? reg_wdata_i[`I2CPC_B_WRITE_COLLISION] : ctl1_r[`I2CPC_B_WRITE_COLLISION]) | write_collision_set;
			ctl1_r[`I2CPC_B_OVF]  <= (wr1 ? reg_wdata_i[`I2CPC_B_OVF] : ctl1_r[`I2CPC_B_OVF]) | ovf_set;
			if (wr1) begin
				ctl1_r[`I2CPC_B_EN] <= reg_wdata_i[`I2CPC_B_EN];
				ctl1_r[3:0]         <= reg_wdata_i[3:0];
			end
			if (ckp_clr) begin
				ctl1_r[`I2CPC_B_CKP] <= 1'b0;
			end else if (wr1) begin
				ctl1_r[`I2CPC_B_CKP] <= reg_wdata_i[`I2CPC_B_CKP];
			end
		end
	end

	// Control register two.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctl2_r <= `I2CPC_CTL_RST;
		end else begin
			if (wr2) begin
				ctl2_r[`I2CPC_B_GENERAL_CALL_IRQ_ENABLE]  <= reg_wdata_i[`I2CPC_B_GENERAL_CALL_IRQ_ENABLE];
				ctl2_r[`I2CPC_B_ACK_VALUE_TO_SEND] <= reg_wdata_i[`I2CPC_B_ACK_VALUE_TO_SEND];
			end
			if (ack_set) begin
				ctl2_r[`I2CPC_B_ACK_RECEIVED_STATUS] <= sda_s_r;
			end else if (wr2) begin
				ctl2_r[`I2CPC_B_ACK_RECEIVED_STATUS] <= reg_wdata_i[`I2CPC_B_ACK_RECEIVED_STATUS];
			end
			if (wr2 && !active) begin
				ctl2_r[4:0] <= reg_wdata_i[4:0] & ~req_clr;
			end else begin
				ctl2_r[4:0] <= ctl2_r[4:0] & ~req_clr;
			end
		end
	end

	// Address and mask registers sharing one location.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			addr_r <= `I2CPC_ADDR_RST;
			msk_r  <= `I2CPC_MSK_RST;
		end else if (wra) begin
			if (msk_sel) begin
				msk_r <= reg_wdata_i;
			end else begin
				addr_r <= reg_wdata_i;
			end
		end
	end

	// Transfer buffer and its full flag.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			buf_r <= '0;
			bf_r  <= 1'b0;
		end else if (rx_load && !bf_r && !ctl1_r[`I2CPC_B_OVF]) begin
			buf_r <= msh_r;
			bf_r  <= 1'b1;
		end else if (sv_load && !ovf_set) begin
			buf_r <= ssh_r;
			bf_r  <= 1'b1;
		end else if (wrb && !write_collision_set) begin
			buf_r <= reg_wdata_i;
			bf_r  <= 1'b1;
		end else if (rdb || (ms_r == MS_TX && m_done) || (sv_tx_r && fall && cnt_r == `I2CPC_BIT_ACK)) begin
			bf_r <= 1'b0;
		end
	end

	// Master engine, stepped by quarter-period ticks.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !mst_md) begin
			ms_r  <= MS_IDLE;
			ph_r  <= 2'h0;
			bit_r <= 4'h0;
			msh_r <= '0;
			tip_r <= 1'b0;
		end else if (ms_r == MS_IDLE) begin
			ph_r  <= 2'h0;
			bit_r <= 4'h0;
			if (wrb && !active) begin
				ms_r  <= MS_TX;
				msh_r <= reg_wdata_i;
				tip_r <= 1'b1;
			end else if (ctl2_r[`I2CPC_B_SEN]) begin
				ms_r <= MS_START;
			end else if (ctl2_r[`I2CPC_B_RESTART_REQUEST]) begin
				ms_r <= MS_RSTART;
			end else if (ctl2_r[`I2CPC_B_PEN]) begin
				ms_r <= MS_STOP;
			end else if (ctl2_r[`I2CPC_B_MASTER_RECEIVE_REQUEST]) begin
				ms_r <= MS_RX;
			end else if (ctl2_r[`I2CPC_B_ACK_SEQUENCE_REQUEST]) begin
				ms_r <= MS_ACK;
			end
		end else if (brg.tick) begin
			ph_r <= ph_r + 2'h1;
			if (m_smp && ms_r == MS_RX) begin
				msh_r <= {msh_r[6:0], sda_s_r};
			end
			if (m_end) begin
				bit_r <= bit_r + 4'h1;
				if (ms_r == MS_TX) begin
					msh_r <= {msh_r[6:0], 1'b0};
				end
				if (m_done) begin
					ms_r  <= MS_IDLE;
					tip_r <= 1'b0;
				end
			end
		end
	end

	// Slave receiver and transmitter; idle outside the slave modes.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !slv_md || stop_c) begin
			{sv_on_r, sv_adr_r, sv_hit_r, sv_tx_r, sv_busy_r, sv_ack_r} <= 6'h00;
			cnt_r <= 4'h0;
			ssh_r <= '0;
			txs_r <= '0;
		end else if (start_c) begin
			{sv_on_r, sv_adr_r, sv_hit_r, sv_tx_r, sv_busy_r, sv_ack_r} <= 6'h30;
			cnt_r <= 4'h0;
		end else if (sv_on_r && rise) begin
			if (cnt_r < `I2CPC_BIT_ACK) begin
				ssh_r <= {ssh_r[6:0], sda_s_r};
				cnt_r <= cnt_r + 4'h1;
			end else if (sv_tx_r && sda_s_r) begin
				sv_tx_r <= 1'b0;
			end
		end else if (sv_on_r && fall) begin
			if (cnt_r == `I2CPC_BIT_ACK) begin
				cnt_r     <= `I2CPC_BIT_END;
				sv_busy_r <= 1'b0;
				if (sv_adr_r) begin
					sv_hit_r <= hit_now;
					sv_tx_r  <= hit_now && ssh_r[0];
				end
				sv_ack_r <= sv_load && !ovf_set;
			end else if (cnt_r == `I2CPC_BIT_END) begin
				cnt_r    <= 4'h0;
				sv_ack_r <= 1'b0;
				sv_adr_r <= 1'b0;
				if (sv_tx_r) begin
					txs_r     <= buf_r;
					sv_busy_r <= 1'b1;
				end
			end else if (sv_busy_r) begin
				txs_r <= {txs_r[6:0], 1'b1};
			end
		end
	end

	// Pin drivers and event output, all registered.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			sda_oe_r <= 1'b0;
			scl_oe_r <= 1'b0;
			own_r    <= 1'b0;
			evt_r    <= 1'b0;
		end else begin
			own_r    <= en;
			sda_oe_r <= mst_md ? m_sda_low : slv_md && (sv_ack_r || (sv_busy_r && !txs_r[7]));
			scl_oe_r <= mst_md ? m_scl_low : slv_md && !ctl1_r[`I2CPC_B_CKP];
			evt_r    <= m_done || sv_load || (slv_md && ss_ev && (start_c || stop_c));
		end
	end

	// Register read port; a buffer read clears the full flag.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !reg_re_i) begin
			rdata_r <= '0;
		end else begin
			unique case (reg_addr_i)
				`I2CPC_OFS_CTL1: rdata_r <= ctl1_r;
				`I2CPC_OFS_CTL2: rdata_r <= ctl2_r;
				`I2CPC_OFS_BUF:  rdata_r <= buf_r;
				`I2CPC_OFS_ADDR: rdata_r <= msk_sel ? msk_r : addr_r;
				`I2CPC_OFS_STAT: rdata_r <= {`I2CPC_STAT_PAD, sv_tx_r, sv_on_r, bf_r, tip_r};
				default:         rdata_r <= '0;
			endcase
		end
	end

	assign reg_rdata_o           = rdata_r;
	assign serial_data_pin_o     = 1'b0;
	assign serial_clock_pin_o    = 1'b0;
	assign serial_data_pin_oe_o  = sda_oe_r;
	assign serial_clock_pin_oe_o = scl_oe_r;
	assign pins_to_port_o        = own_r;
	assign port_event_o          = evt_r;
endmodule

// file: tb/i2cpc_top_props.sv
// Port-level assertions for the two-wire port control block.
`timescale 1ns/1ns
`include "i2cpc_params.svh"
module i2cpc_top_props (
	input wire logic       clk_i,                  // clock
	input wire logic       sys_rst_i,              // reset
	input wire logic [2:0] reg_addr_i,             // index
	input wire logic [7:0] reg_wdata_i,            // write data
	input wire logic       reg_we_i,               // write strobe
	input wire logic       reg_re_i,               // read strobe
	input wire logic [7:0] reg_rdata_o,            // read data
	input wire logic       mask_mode_config_bit_i, // masking config
	input wire logic       serial_data_pin_i,      // data line
	input wire logic       serial_data_pin_o,      // data value
	input wire logic       serial_data_pin_oe_o,   // data pulled low
	input wire logic       serial_clock_pin_i,     // clock line
	input wire logic       serial_clock_pin_o,     // clock value
	input wire logic       serial_clock_pin_oe_o,  // clock pulled low
	input wire logic       pins_to_port_o,         // pins owned
	input wire logic       port_event_o            // event pulse
);
	logic       en_sh, en_q, ckp_sh, wr1, wr2, mst, fwm, slv, other;
	logic [3:0] md_sh;
	logic [6:0] rl_sh;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	assign wr1   = reg_we_i && reg_addr_i == `I2CPC_OFS_CTL1;
	assign wr2   = reg_we_i && reg_addr_i == `I2CPC_OFS_CTL2;
	assign mst   = en_sh && md_sh == 4'h8 && rl_sh < 7'h04;
	assign fwm   = en_sh && md_sh == 4'hB && rl_sh < 7'h04;
	assign slv   = en_sh && md_sh inside {4'h6, 4'h7, 4'hE, 4'hF};
	assign other = en_sh && !(md_sh inside {4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hE, 4'hF});
	// Shadow of the fields software wrote; hardware only ever clears the release bit.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			en_sh  <= 1'b0;
			ckp_sh <= 1'b0;
			md_sh  <= 4'h0;
		end else if (wr1) begin
			en_sh  <= reg_wdata_i[5];
			ckp_sh <= reg_wdata_i[4];
			md_sh  <= reg_wdata_i[3:0];
		end
	end
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rl_sh <= 7'h00;
		end else if (reg_we_i && reg_addr_i == `I2CPC_OFS_ADDR && !(md_sh == 4'h9 && mask_mode_config_bit_i)) begin
			rl_sh <= reg_wdata_i[6:0];
		end
	end
	always_ff @(posedge clk_i) begin
		en_q <= sys_rst_i ? 1'b0 : en_sh;
	end
	property p_pins_follow;
		pins_to_port_o == en_q;
	endproperty
	a_pins_follow: assert property (p_pins_follow)
		else $error("pin ownership differs from enable bit");
	property p_off_quiet;
		(!en_sh)[*3] |-> !serial_clock_pin_oe_o && !serial_data_pin_oe_o;
	endproperty
	a_off_quiet: assert property (p_off_quiet)
		else $error("disabled port drives a pin");
	property p_reset;
		$fell(sys_rst_i) |-> reg_rdata_o == 8'h00 && !pins_to_port_o && !port_event_o
			&& !serial_data_pin_oe_o && !serial_clock_pin_oe_o;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not idle after reset");
	property p_evt_pulse;
		port_event_o |=> !port_event_o;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse)
		else $error("event longer than one cycle");
	property p_other_quiet;
		other[*3] |-> !serial_clock_pin_oe_o && !serial_data_pin_oe_o;
	endproperty
	a_other_quiet: assert property (p_other_quiet)
		else $error("unlisted mode drives a pin");
	property p_slave_hold;
		(slv && !ckp_sh)[*3] |-> serial_clock_pin_oe_o;
	endproperty
	a_slave_hold: assert property (p_slave_hold)
		else $error("slave clock not held low");
	property p_start_done;
		wr2 && reg_wdata_i[0] && mst |-> ##[1:300] port_event_o;
	endproperty
	a_start_done: assert property (p_start_done)
		else $error("start request never completed");
	property p_fw_done;
		wr2 && reg_wdata_i[4:0] != 5'h00 && fwm |-> ##[1:300] port_event_o;
	endproperty
	a_fw_done: assert property (p_fw_done)
		else $error("firmware master request never completed");
endmodule

// file: tb/i2cpc_slave_model.sv
// Two-wire slave model: acknowledges written bytes and serves read bytes.
`timescale 1ns/1ns
module i2cpc_slave_model (
	input  wire logic       scl_i,    // clock line
	input  wire logic       sda_i,    // data line
	input  wire logic       ack_en_i, // acknowledge writes
	input  wire logic       rd_i,     // serve read data
	input  wire logic [7:0] byte_i,   // byte served
	output logic            sda_oe_o  // pull data low
);
	int cnt = 0;
	int pos = 9;
	always @(negedge sda_i) begin
		if (scl_i === 1'b1) begin
			cnt = 0;
			pos = 9;
		end
	end
	always @(posedge scl_i) begin
		cnt = cnt + 1;
	end
	// The drive position moves on a clock fall, or to 9 on a start, so data changes while the clock is high only at a start.
	always @(negedge scl_i) begin
		if (cnt >= 9) begin
			cnt = 0;
		end
		pos = cnt;
	end
	assign sda_oe_o = rd_i ? (pos < 8 && !byte_i[7 - pos]) : (ack_en_i && pos == 8);
endmodule

// file: tb/tb_i2c_port_control_registers.sv
// Bench for the two-wire port control registers with a slave on the bus.
`timescale 1ns/1ns
`include "i2cpc_params.svh"
module tb_i2c_port_control_registers;
	logic       clk_i       = 1'b0;
	logic       sys_rst_i   = 1'b1;
	logic [2:0] reg_addr_i  = 3'h0;
	logic [7:0] reg_wdata_i = 8'h00;
	logic       reg_we_i    = 1'b0;
	logic       reg_re_i    = 1'b0;
	logic [7:0] reg_rdata_o;
	logic       sda_oe, scl_oe, m_oe, pins, evt, sda, scl;
	logic       ack_en      = 1'b1;
	logic       rd          = 1'b0;
	logic [7:0] sbyte       = 8'h5A;
	logic [8:0] shf         = 9'h000;
	int         miscompares = 0;
	int         n_compared  = 0;
	int         cycles      = 0;
	int         starts      = 0;
	int         stops       = 0;
	int         t0;
	always #4 clk_i = ~clk_i;
	// Both lines are open drain with pull-ups.
	assign scl = !scl_oe;
	assign sda = !(sda_oe || m_oe);
	always @(negedge sda) if (scl === 1'b1) starts++;
	always @(posedge sda) if (scl === 1'b1) stops++;
	always @(posedge scl) shf = {shf[7:0], sda};
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end
	i2cpc_top dut_u (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .mask_mode_config_bit_i(1'b1),
		.serial_data_pin_i(sda), .serial_data_pin_o(), .serial_data_pin_oe_o(sda_oe),
		.serial_clock_pin_i(scl), .serial_clock_pin_o(), .serial_clock_pin_oe_o(scl_oe),
		.pins_to_port_o(pins), .port_event_o(evt)
	);
	i2cpc_slave_model slave_u (.scl_i(scl), .sda_i(sda), .ack_en_i(ack_en), .rd_i(rd), .byte_i(sbyte), .sda_oe_o(m_oe));
	task automatic chk(input string what, input logic [8:0] e, input logic [8:0] g);
		n_compared++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_we_i    <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1;
		chk(what, {1'b0, e}, {1'b0, reg_rdata_o & m});
		@(posedge clk_i);
	endtask
	task automatic wait_evt(input string what);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while (evt !== 1'b1 && n < 600);
		chk(what, 9'h001, {8'h00, evt});
		@(posedge clk_i);
	endtask
	task automatic finish_test();
		if (miscompares == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		rchk("ctl1", `I2CPC_OFS_CTL1, 8'hFF, 8'h00);
		rchk("ctl2", `I2CPC_OFS_CTL2, 8'hFF, 8'h00);
		rchk("addr", `I2CPC_OFS_ADDR, 8'hFF, 8'h00);
		wr(`I2CPC_OFS_ADDR, 8'h83);
		wr(`I2CPC_OFS_CTL1, 8'h28);
		#1;
		chk("pins", 9'h001, {8'h00, pins});
		@(posedge clk_i);
		t0 = starts;
		wr(`I2CPC_OFS_CTL2, 8'h01);
		wr(`I2CPC_OFS_CTL2, 8'h04);
		wr(`I2CPC_OFS_BUF, 8'hAA);
		rchk("ctl2 busy", `I2CPC_OFS_CTL2, 8'h1F, 8'h01);
		rchk("collision", `I2CPC_OFS_CTL1, 8'hFF, 8'hA8);
		wait_evt("start");
		chk("starts", 9'(t0 + 1), 9'(starts));
		rchk("ctl2 start", `I2CPC_OFS_CTL2, 8'h1F, 8'h00);
		wr(`I2CPC_OFS_CTL1, 8'h28);
		rchk("ctl1 clear", `I2CPC_OFS_CTL1, 8'hFF, 8'h28);
		wr(`I2CPC_OFS_BUF, 8'hA5);
		@(posedge scl);
		t0 = cycles;
		@(posedge scl);
		chk("period", 9'h010, 9'(cycles - t0));
		wait_evt("tx ack");
		chk("tx bits", {8'hA5, 1'b0}, shf);
		rchk("acked", `I2CPC_OFS_CTL2, 8'h40, 8'h00);
		ack_en <= 1'b0;
		wr(`I2CPC_OFS_BUF, 8'h3C);
		wait_evt("tx nack");
		chk("tx bits", {8'h3C, 1'b1}, shf);
		rchk("nacked", `I2CPC_OFS_CTL2, 8'h40, 8'h40);
		wr(`I2CPC_OFS_CTL1, 8'h2B);
		t0 = starts;
		wr(`I2CPC_OFS_CTL2, 8'h02);
		wait_evt("restart");
		chk("starts", 9'(t0 + 1), 9'(starts));
		rchk("ctl2 rs", `I2CPC_OFS_CTL2, 8'h1F, 8'h00);
		rd <= 1'b1;
		wr(`I2CPC_OFS_CTL2, 8'h08);
		wait_evt("rx");
		rchk("ctl2 rx", `I2CPC_OFS_CTL2, 8'h1F, 8'h00);
		sbyte <= 8'hC3;
		wr(`I2CPC_OFS_CTL2, 8'h10);
		wait_evt("ack");
		chk("ack bit", 9'h000, {8'h00, shf[0]});
		rchk("ctl2 ack", `I2CPC_OFS_CTL2, 8'h1F, 8'h00);
		wr(`I2CPC_OFS_CTL2, 8'h08);
		wait_evt("rx2");
		rchk("overflow", `I2CPC_OFS_CTL1, 8'hFF, 8'h6B);
		rchk("buffer", `I2CPC_OFS_BUF, 8'hFF, 8'h5A);
		wr(`I2CPC_OFS_CTL2, 8'h30);
		wait_evt("nack");
		chk("ack bit", 9'h001, {8'h00, shf[0]});
		rd <= 1'b0;
		t0 = stops;
		wr(`I2CPC_OFS_CTL2, 8'h04);
		wait_evt("stop");
		chk("stops", 9'(t0 + 1), 9'(stops));
		rchk("ctl2 stop", `I2CPC_OFS_CTL2, 8'h1F, 8'h00);
		wr(`I2CPC_OFS_CTL1, 8'h2B);
		rchk("ov clear", `I2CPC_OFS_CTL1, 8'hFF, 8'h2B);
		wr(`I2CPC_OFS_CTL1, 8'h29);
		rchk("mask rst", `I2CPC_OFS_ADDR, 8'hFF, 8'hFF);
		wr(`I2CPC_OFS_ADDR, 8'h55);
		rchk("mask", `I2CPC_OFS_ADDR, 8'hFF, 8'h55);
		wr(`I2CPC_OFS_CTL1, 8'h28);
		rchk("reload", `I2CPC_OFS_ADDR, 8'hFF, 8'h83);
		wr(`I2CPC_OFS_CTL1, 8'h26);
		repeat (3) @(posedge clk_i);
		#1;
		chk("hold", 9'h001, {8'h00, scl_oe});
		@(posedge clk_i);
		wr(`I2CPC_OFS_CTL1, 8'h36);
		repeat (3) @(posedge clk_i);
		#1;
		chk("release", 9'h000, {8'h00, scl_oe});
		@(posedge clk_i);
		t0 = starts;
		wr(`I2CPC_OFS_CTL1, 8'h22);
		wr(`I2CPC_OFS_CTL2, 8'h01);
		repeat (40) @(posedge clk_i);
		chk("no start", 9'(t0), 9'(starts));
		wr(`I2CPC_OFS_CTL1, 8'h00);
		#1;
		chk("pins", 9'h000, {8'h00, pins});
		@(posedge clk_i);
		wr(3'h5, 8'h77);
		rchk("unmapped", 3'h5, 8'hFF, 8'h00);
		finish_test();
	end
endmodule
bind i2cpc_top i2cpc_top_props props_u (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
	.reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
	.mask_mode_config_bit_i(mask_mode_config_bit_i), .serial_data_pin_i(serial_data_pin_i),
	.serial_data_pin_o(serial_data_pin_o), .serial_data_pin_oe_o(serial_data_pin_oe_o),
	.serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
	.serial_clock_pin_oe_o(serial_clock_pin_oe_o), .pins_to_port_o(pins_to_port_o), .port_event_o(port_event_o)
);
